// File: inc/codec_ctrl_pkg.sv
// Constants, field positions and types of the codec mode-control block.
// Assumes 8-bit registers reached through a byte-wide register port.
package codec_ctrl_pkg;
    // Register offsets
    localparam logic [7:0] OFF_POWER = 8'h02;
    localparam logic [7:0] OFF_PLAYBACK = 8'h03;
    localparam logic [7:0] OFF_RECORD = 8'h04;
    localparam logic [7:0] OFF_CLKDIV = 8'h05;
    localparam logic [7:0] OFF_ROUTING = 8'h06;
    localparam logic [7:0] OFF_GAIN_LEFT = 8'h07;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Reset values; reserved bits keep these forever
    localparam logic [7:0] RST_POWER = 8'h01;
    localparam logic [7:0] RST_PLAYBACK = 8'h08;
    localparam logic [7:0] RST_RECORD = 8'h00;
    localparam logic [7:0] RST_CLKDIV = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h40;
    localparam logic [7:0] RST_GAIN = 8'h00;

    // Writable bits per register
    localparam logic [7:0] WM_POWER = 8'h01;
    localparam logic [7:0] WM_PLAYBACK = 8'hf7;
    localparam logic [7:0] WM_RECORD = 8'hd7;
    localparam logic [7:0] WM_CLKDIV = 8'h77;
    localparam logic [7:0] WM_ROUTING = 8'h63;
    localparam logic [7:0] WM_GAIN = 8'h3f;

    // Field positions
    localparam int POS_SLEEP = 0;
    localparam int POS_SPEED = 6;
    localparam int POS_FORMAT = 4;
    localparam int POS_SILENCE = 2;
    localparam int POS_EMPHASIS = 1;
    localparam int POS_HOLD = 1;
    localparam int POS_ROLE = 0;
    localparam int POS_DIV_PRIMARY = 4;
    localparam int POS_DIV_SECONDARY = 0;
    localparam int POS_AUX = 5;
    localparam int POS_LOOP = 1;
    localparam int POS_INDEP = 0;
    localparam int GAIN_W = 6;

    typedef enum logic [1:0] {
        SPEED_SINGLE = 2'b00,
        SPEED_DOUBLE = 2'b01,
        SPEED_QUAD = 2'b10,
        SPEED_RESERVED = 2'b11
    } speed_t;

    typedef enum logic [1:0] {
        AUX_HIGH_Z = 2'b00,
        AUX_PLAYBACK = 2'b01,
        AUX_GAIN_STAGE = 2'b10,
        AUX_RESERVED = 2'b11
    } aux_t;

    // Divider codes and the divide ratio times two
    localparam logic [2:0] DIV_CODE_1 = 3'h0;
    localparam logic [2:0] DIV_CODE_1P5 = 3'h1;
    localparam logic [2:0] DIV_CODE_2 = 3'h2;
    localparam logic [2:0] DIV_CODE_3 = 3'h3;
    localparam logic [2:0] DIV_CODE_4 = 3'h4;
    localparam logic [3:0] DIV_X2_1 = 4'h2;
    localparam logic [3:0] DIV_X2_1P5 = 4'h3;
    localparam logic [3:0] DIV_X2_2 = 4'h4;
    localparam logic [3:0] DIV_X2_3 = 4'h6;
    localparam logic [3:0] DIV_X2_4 = 4'h8;

    // Gain limits in half-dB steps, two's complement
    localparam logic signed [5:0] GAIN_MIN = 6'sh28;
    localparam logic signed [5:0] GAIN_MAX = 6'sh18;

    // Level engine: attenuation in 1/8 dB, one step per word clock
    localparam int CHANNELS = 2;
    localparam int LEVEL_W = 10;
    localparam logic [9:0] LEVEL_UNITY = 10'h000;
    localparam logic [9:0] LEVEL_MUTE = 10'h3fc;
    localparam logic [9:0] ZC_TIMEOUT = 10'h1ff;
endpackage

// File: inc/level_ramp_if.sv
// Carrier between the control registers and the playback level engine.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface level_ramp_if;
    logic word_tick;
    logic [codec_ctrl_pkg::CHANNELS-1:0] sample_sign;
    logic soft_en;
    logic zero_en;
    logic [codec_ctrl_pkg::LEVEL_W-1:0] target;
    logic [codec_ctrl_pkg::CHANNELS-1:0][codec_ctrl_pkg::LEVEL_W-1:0] level;
    logic [codec_ctrl_pkg::CHANNELS-1:0] settled;

    modport engine (
        input word_tick, sample_sign, soft_en, zero_en, target,
        output level, settled
    );
    modport ctrl (
        output word_tick, sample_sign, soft_en, zero_en, target,
        input level, settled
    );
endinterface

// File: design/level_ramp.sv
// Per-channel playback level engine: immediate, soft ramp or zero cross.
// Assumes word_tick is a one-cycle pulse per sample on sys_clk.
`timescale 1ns/1ps
module level_ramp (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Controls and levels
    level_ramp_if.engine lr
);
    for (genvar ch = 0; ch < codec_ctrl_pkg::CHANNELS; ch++) begin : g_ch
        logic [codec_ctrl_pkg::LEVEL_W-1:0] level_ff;
        logic [codec_ctrl_pkg::LEVEL_W-1:0] wait_ff;
        logic sign_ff;
        logic pending;
        logic crossing;
        logic timeout;
        logic gate;
        logic apply;

        assign pending = level_ff != lr.target;
        assign crossing = lr.word_tick && (lr.sample_sign[ch] != sign_ff);
        assign timeout = lr.word_tick && (wait_ff == codec_ctrl_pkg::ZC_TIMEOUT);
        assign gate = !lr.zero_en || crossing || timeout;
        // Soft steps only on word ticks; immediate changes any cycle when zero cross is off
        assign apply = pending && gate && (lr.word_tick || !lr.soft_en);

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                sign_ff <= 1'b0;
            end else if (lr.word_tick) begin
                sign_ff <= lr.sample_sign[ch];
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst || !pending || apply) begin
                wait_ff <= '0;
            end else if (lr.word_tick) begin
                wait_ff <= wait_ff + 10'h001;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                level_ff <= codec_ctrl_pkg::LEVEL_UNITY;
            end else if (apply) begin
                if (lr.soft_en) begin
                    level_ff <= (level_ff < lr.target) ? level_ff + 10'h001 : level_ff - 10'h001;
                end else begin
                    level_ff <= lr.target;
                end
            end
        end

        assign lr.level[ch] = level_ff;
        assign lr.settled[ch] = !pending;
    end
endmodule

// File: design/codec_mode_control_regs.sv
// Mode-control register bank of a stereo codec and its decoded controls.
// Assumes a control-port decoder presents byte accesses on sys_clk.
`timescale 1ns/1ps
// What this block does
// - Sleep bit set holds device in low power, no conversion.
// - Sleep bit resets set; host clears it to start operation.
// - Sleep never alters any stored register value.
// - Playback speed field selects single, double or quad rate; 11 reserved.
// - Record speed field selects single, double or quad rate; 11 reserved.
// - Playback format: left justified, I2S, right justified 16 or 24.
// - Record format bit: left justified at reset, I2S when set.
// - Playback silence mutes outputs and drives mute pin low.
// - Playback silence uses the soft ramp and zero cross settings.
// - Emphasis undo for 44.1 kHz, off at reset, single speed only.
// - Playback role bit makes port 2 clock master when set.
// - Record silence forces zero record data on both channels.
// - Filter hold freezes offset estimate and keeps subtracting it.
// - Record role bit makes port 1 clock master when set.
// - Primary divider codes 0..4 give 1, 1.5, 2, 3, 4.
// - Secondary divider codes 0..4 give 1, 1.5, 2, 3, 4.
// - Aux source: high impedance, playback output, gain stage; 11 reserved.
// - Loopback routes record data into playback path.
// - Independent rate uses both master clocks, else primary only.
// - Gain field is two's complement half dB, -12 to +12 dB.
// - Soft ramp moves level 1/8 dB per word clock.
// - Zero cross applies change at crossing or after timeout.
module codec_mode_control_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Level-change mode bits kept elsewhere
    input wire logic playback_gradual_change,
    input wire logic playback_crossing_sync,
    // Playback datapath inputs
    input wire logic playback_word_clock,
    input wire logic [1:0] playback_sample_sign,
    // Power state
    output logic device_sleep,
    output logic playback_run,
    output logic record_run,
    // Playback controls
    output logic [1:0] playback_speed_range,
    output logic [1:0] playback_serial_format,
    output logic emphasis_undo_enable,
    output logic port2_clock_master,
    output logic external_mute_control_n,
    output logic [9:0] playback_level_left,
    output logic [9:0] playback_level_right,
    output logic playback_level_settled,
    // Record controls
    output logic [1:0] record_speed_range,
    output logic record_serial_format,
    output logic record_silence,
    output logic offset_filter_hold,
    output logic port1_clock_master,
    // Clocking and routing
    output logic [3:0] primary_clock_divider,
    output logic [3:0] secondary_clock_divider,
    output logic record_clock_secondary,
    output logic [1:0] aux_output_source,
    output logic loopback_enable,
    output logic independent_rate_enable,
    // Gain stage and configuration check
    output logic [5:0] left_gain_stage,
    output logic left_gain_valid,
    output logic config_fault
);
    logic [7:0] power_ff;
    logic [7:0] playback_control_ff;
    logic [7:0] record_control_ff;
    logic [7:0] master_clock_divide_ff;
    logic [7:0] signal_routing_ff;
    logic [7:0] left_gain_stage_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic wclk_meta_ff;
    logic wclk_sync_ff;
    logic wclk_prev_ff;
    logic sleep;
    logic [1:0] pb_speed;
    logic [1:0] rec_speed;
    logic [2:0] div_primary;
    logic [2:0] div_secondary;
    logic [1:0] aux_sel;
    logic signed [5:0] gain;
    logic div_fault;
    logic [3:0] div_primary_x2;
    logic [3:0] div_secondary_x2;
    logic [1:0] nxt_fault;
    logic gain_ok;

    level_ramp_if lr ();

    // Decodes a divider code; bit 4 of the result flags a reserved code
    function automatic logic [4:0] divide_decode(input logic [2:0] code);
        logic [4:0] res;
        res = {1'b0, codec_ctrl_pkg::DIV_X2_1};
        unique case (code)
            codec_ctrl_pkg::DIV_CODE_1: res = {1'b0, codec_ctrl_pkg::DIV_X2_1};
            codec_ctrl_pkg::DIV_CODE_1P5: res = {1'b0, codec_ctrl_pkg::DIV_X2_1P5};
            codec_ctrl_pkg::DIV_CODE_2: res = {1'b0, codec_ctrl_pkg::DIV_X2_2};
            codec_ctrl_pkg::DIV_CODE_3: res = {1'b0, codec_ctrl_pkg::DIV_X2_3};
            codec_ctrl_pkg::DIV_CODE_4: res = {1'b0, codec_ctrl_pkg::DIV_X2_4};
            default: res = {1'b1, codec_ctrl_pkg::DIV_X2_1};
        endcase
        return res;
    endfunction

    // sleep bit comes out of reset set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            power_ff <= codec_ctrl_pkg::RST_POWER;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_POWER) begin
            power_ff <= (reg_wdata & codec_ctrl_pkg::WM_POWER) |
                        (codec_ctrl_pkg::RST_POWER & ~codec_ctrl_pkg::WM_POWER);
        end
    end

    // reserved bits keep their fixed value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            playback_control_ff <= codec_ctrl_pkg::RST_PLAYBACK;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_PLAYBACK) begin
            playback_control_ff <= (reg_wdata & codec_ctrl_pkg::WM_PLAYBACK) |
                                   (codec_ctrl_pkg::RST_PLAYBACK & ~codec_ctrl_pkg::WM_PLAYBACK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            record_control_ff <= codec_ctrl_pkg::RST_RECORD;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_RECORD) begin
            record_control_ff <= (reg_wdata & codec_ctrl_pkg::WM_RECORD) |
                                 (codec_ctrl_pkg::RST_RECORD & ~codec_ctrl_pkg::WM_RECORD);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            master_clock_divide_ff <= codec_ctrl_pkg::RST_CLKDIV;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_CLKDIV) begin
            master_clock_divide_ff <= (reg_wdata & codec_ctrl_pkg::WM_CLKDIV) |
                                      (codec_ctrl_pkg::RST_CLKDIV & ~codec_ctrl_pkg::WM_CLKDIV);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            signal_routing_ff <= codec_ctrl_pkg::RST_ROUTING;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_ROUTING) begin
            signal_routing_ff <= (reg_wdata & codec_ctrl_pkg::WM_ROUTING) |
                                 (codec_ctrl_pkg::RST_ROUTING & ~codec_ctrl_pkg::WM_ROUTING);
        end
    end

    // out-of-range codes are stored but flagged
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            left_gain_stage_ff <= codec_ctrl_pkg::RST_GAIN;
        end else if (reg_wr && reg_addr == codec_ctrl_pkg::OFF_GAIN_LEFT) begin
            left_gain_stage_ff <= (reg_wdata & codec_ctrl_pkg::WM_GAIN) |
                                  (codec_ctrl_pkg::RST_GAIN & ~codec_ctrl_pkg::WM_GAIN);
        end
    end

    always_comb begin
        nxt_rdata = codec_ctrl_pkg::READ_UNMAPPED;
        unique case (reg_addr)
            codec_ctrl_pkg::OFF_POWER: nxt_rdata = power_ff;
            codec_ctrl_pkg::OFF_PLAYBACK: nxt_rdata = playback_control_ff;
            codec_ctrl_pkg::OFF_RECORD: nxt_rdata = record_control_ff;
            codec_ctrl_pkg::OFF_CLKDIV: nxt_rdata = master_clock_divide_ff;
            codec_ctrl_pkg::OFF_ROUTING: nxt_rdata = signal_routing_ff;
            codec_ctrl_pkg::OFF_GAIN_LEFT: nxt_rdata = left_gain_stage_ff;
            default: nxt_rdata = codec_ctrl_pkg::READ_UNMAPPED;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= codec_ctrl_pkg::READ_UNMAPPED;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // Word clock is a pin; the second and third stages feed the edge detector
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wclk_meta_ff <= 1'b0;
            wclk_sync_ff <= 1'b0;
            wclk_prev_ff <= 1'b0;
        end else begin
            wclk_meta_ff <= playback_word_clock;
            wclk_sync_ff <= wclk_meta_ff;
            wclk_prev_ff <= wclk_sync_ff;
        end
    end

    // Field extraction
    assign sleep = power_ff[codec_ctrl_pkg::POS_SLEEP];
    assign pb_speed = playback_control_ff[codec_ctrl_pkg::POS_SPEED +: 2];
    assign rec_speed = record_control_ff[codec_ctrl_pkg::POS_SPEED +: 2];
    assign div_primary = master_clock_divide_ff[codec_ctrl_pkg::POS_DIV_PRIMARY +: 3];
    assign div_secondary = master_clock_divide_ff[codec_ctrl_pkg::POS_DIV_SECONDARY +: 3];
    assign aux_sel = signal_routing_ff[codec_ctrl_pkg::POS_AUX +: 2];
    assign gain = $signed(left_gain_stage_ff[codec_ctrl_pkg::GAIN_W-1:0]);

    assign {div_fault, div_primary_x2} = divide_decode(div_primary);
    assign {nxt_fault[0], div_secondary_x2} = divide_decode(div_secondary);
    assign gain_ok = (gain >= codec_ctrl_pkg::GAIN_MIN) && (gain <= codec_ctrl_pkg::GAIN_MAX);
    assign nxt_fault[1] = (pb_speed == codec_ctrl_pkg::SPEED_RESERVED) ||
                          (rec_speed == codec_ctrl_pkg::SPEED_RESERVED) ||
                          (aux_sel == codec_ctrl_pkg::AUX_RESERVED);

    // silence follows the soft and zero-cross bits
    assign lr.word_tick = wclk_sync_ff & ~wclk_prev_ff;
    assign lr.sample_sign = playback_sample_sign;
    assign lr.soft_en = playback_gradual_change;
    assign lr.zero_en = playback_crossing_sync;
    // silence sets the target level to full attenuation
    assign lr.target = playback_control_ff[codec_ctrl_pkg::POS_SILENCE] ?
                       codec_ctrl_pkg::LEVEL_MUTE : codec_ctrl_pkg::LEVEL_UNITY;

    level_ramp u_level_ramp (
        .sys_clk(sys_clk),
        .rst(rst),
        .lr(lr)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            device_sleep <= 1'b1;
            playback_run <= 1'b0;
            record_run <= 1'b0;
        end else begin
            device_sleep <= sleep;
            playback_run <= ~sleep;
            record_run <= ~sleep;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            playback_speed_range <= codec_ctrl_pkg::SPEED_SINGLE;
            playback_serial_format <= 2'h0;
            emphasis_undo_enable <= 1'b0;
            port2_clock_master <= 1'b0;
            external_mute_control_n <= 1'b1;
            playback_level_left <= codec_ctrl_pkg::LEVEL_UNITY;
            playback_level_right <= codec_ctrl_pkg::LEVEL_UNITY;
            playback_level_settled <= 1'b1;
        end else begin
            playback_speed_range <= pb_speed;
            playback_serial_format <= playback_control_ff[codec_ctrl_pkg::POS_FORMAT +: 2];
            emphasis_undo_enable <= playback_control_ff[codec_ctrl_pkg::POS_EMPHASIS] &&
                                    pb_speed == codec_ctrl_pkg::SPEED_SINGLE;
            port2_clock_master <= playback_control_ff[codec_ctrl_pkg::POS_ROLE];
            external_mute_control_n <= ~playback_control_ff[codec_ctrl_pkg::POS_SILENCE];
            playback_level_left <= lr.level[0];
            playback_level_right <= lr.level[1];
            playback_level_settled <= &lr.settled;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            record_speed_range <= codec_ctrl_pkg::SPEED_SINGLE;
            record_serial_format <= 1'b0;
            record_silence <= 1'b0;
            offset_filter_hold <= 1'b0;
            port1_clock_master <= 1'b0;
        end else begin
            record_speed_range <= rec_speed;
            record_serial_format <= record_control_ff[codec_ctrl_pkg::POS_FORMAT];
            record_silence <= record_control_ff[codec_ctrl_pkg::POS_SILENCE];
            offset_filter_hold <= record_control_ff[codec_ctrl_pkg::POS_HOLD];
            port1_clock_master <= record_control_ff[codec_ctrl_pkg::POS_ROLE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            primary_clock_divider <= codec_ctrl_pkg::DIV_X2_1;
            secondary_clock_divider <= codec_ctrl_pkg::DIV_X2_1;
            record_clock_secondary <= 1'b0;
            aux_output_source <= codec_ctrl_pkg::AUX_PLAYBACK;
            loopback_enable <= 1'b0;
            independent_rate_enable <= 1'b0;
            left_gain_stage <= '0;
            left_gain_valid <= 1'b1;
            config_fault <= 1'b0;
        end else begin
            primary_clock_divider <= div_primary_x2;
            secondary_clock_divider <= div_secondary_x2;
            // record side moves to the secondary clock
            record_clock_secondary <= signal_routing_ff[codec_ctrl_pkg::POS_INDEP];
            independent_rate_enable <= signal_routing_ff[codec_ctrl_pkg::POS_INDEP];
            aux_output_source <= aux_sel;
            loopback_enable <= signal_routing_ff[codec_ctrl_pkg::POS_LOOP];
            left_gain_stage <= gain;
            left_gain_valid <= gain_ok;
            config_fault <= div_fault | (|nxt_fault) | ~gain_ok;
        end
    end
endmodule

// File: tb/codec_mode_control_regs_props.sv
// Port checks for the codec mode-control register bank.
// Assumes one clock domain and a strobe spacing of two cycles.
`timescale 1ns/1ps
module codec_mode_control_regs_props (
    // Clock, reset, register port
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    // Decoded controls
    input wire logic device_sleep,
    input wire logic playback_run,
    input wire logic [1:0] playback_speed_range,
    input wire logic emphasis_undo_enable,
    input wire logic external_mute_control_n,
    input wire logic port2_clock_master,
    input wire logic record_silence
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer_time: assert property (reg_rd |=> reg_rvalid)
        else $error("read answer missing");
    a_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    a_sleep_after_reset: assert property ($fell(rst) |-> device_sleep)
        else $error("sleep clear after reset");
    a_sleep_stops_run: assert property (device_sleep |-> !playback_run)
        else $error("running while asleep");
    a_mute_pin_follows: assert property (reg_wr && reg_addr == 8'h03 |->
        ##2 external_mute_control_n == !$past(reg_wdata[2], 2)) else $error("mute pin wrong");
    a_emphasis_single_only: assert property (emphasis_undo_enable |-> playback_speed_range == 2'b00)
        else $error("emphasis outside single speed");
    a_port2_role_bit: assert property (reg_wr && reg_addr == 8'h03 |->
        ##2 port2_clock_master == $past(reg_wdata[0], 2)) else $error("port 2 role wrong");
    a_record_mute_bit: assert property (reg_wr && reg_addr == 8'h04 |->
        ##2 record_silence == $past(reg_wdata[2], 2)) else $error("record silence wrong");
endmodule
bind codec_mode_control_regs codec_mode_control_regs_props chk (.sys_clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rvalid, .device_sleep, .playback_run, .playback_speed_range,
    .emphasis_undo_enable, .external_mute_control_n, .port2_clock_master, .record_silence);

// File: tb/codec_host.sv
// Host model driving the byte register port.
// Assumes its tasks are called from one process only.
`timescale 1ns/1ps
module codec_host (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One-cycle strobe; the idle cycle after it keeps accesses apart
    task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic wake;
        cycle(8'h02, 8'h00, 1'b1);
    endtask
endmodule

// File: tb/test_codec_mode_control_regs.sv
// Self-checking bench of the codec mode-control register bank.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ps
module test_codec_mode_control_regs;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic gradual = 1'b0;
    logic crossing = 1'b0;
    logic word_clk = 1'b0;
    logic [1:0] sign = 2'b00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, device_sleep, playback_run, emph, mute_n, rec_fmt, gain_ok, fault;
    logic [1:0] pb_speed, pb_fmt, rec_speed, aux;
    logic [3:0] div1, div2;
    logic [9:0] level, level_r;
    int errors = 0, cmp_count = 0;
    logic [31:0] lfsr = 32'hf938;
    logic [7:0] exp_q[$];
    logic [7:0] adr[6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    logic [7:0] rstv[6] = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [7:0] msk[6] = '{8'h00, 8'h77, 8'h57, 8'h33, 8'h23, 8'h0f};
    logic [7:0] shadow[6];
    logic [3:0] ratio[5] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
    always #20 sys_clk = ~sys_clk;
    codec_host host (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    codec_mode_control_regs dut (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_rvalid, .playback_gradual_change(gradual), .playback_crossing_sync(crossing),
        .playback_word_clock(word_clk), .playback_sample_sign(sign), .device_sleep, .playback_run,
        .record_run(), .playback_speed_range(pb_speed), .playback_serial_format(pb_fmt),
        .emphasis_undo_enable(emph), .port2_clock_master(), .external_mute_control_n(mute_n),
        .playback_level_left(level), .playback_level_right(level_r), .playback_level_settled(),
        .record_speed_range(rec_speed), .record_serial_format(rec_fmt), .record_silence(),
        .offset_filter_hold(), .port1_clock_master(), .primary_clock_divider(div1),
        .secondary_clock_divider(div2), .record_clock_secondary(), .aux_output_source(aux),
        .loopback_enable(), .independent_rate_enable(), .left_gain_stage(), .left_gain_valid(gain_ok),
        .config_fault(fault));
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.cycle(a, d, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.cycle(a, 8'h00, 1'b0);
    endtask
    task automatic ticks(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge sys_clk);
            #1;
            lfsr = step(lfsr);
            if (!crossing && !word_clk) sign = lfsr[1:0];
            word_clk = ~word_clk;
        end
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic test_done;
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 10'h000, 10'h3ff);
            else chk("reg_rdata", {2'b00, exp_q.pop_front()}, {2'b00, reg_rdata});
        end
    end
    initial begin
        #(20000 * 40);
        errors++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk("device_sleep", 10'h001, {9'h0, device_sleep});
        foreach (adr[i]) rd(adr[i], rstv[i]);
        rd(8'h20, 8'h00);
        host.wake();
        for (int i = 1; i < 6; i++) begin
            lfsr = step(lfsr);
            shadow[i] = lfsr[7:0] & msk[i];
            wr(adr[i], shadow[i]);
        end
        chk("playback_run", 10'h001, {9'h0, playback_run});
        wr(8'h02, 8'h01);
        for (int i = 1; i < 6; i++) rd(adr[i], shadow[i] | (rstv[i] & 8'h08));
        wr(8'h02, 8'h00);
        for (int c = 0; c < 5; c++) begin
            wr(8'h05, {1'b0, c[2:0], 1'b0, c[2:0]});
            chk("primary divider", {6'h0, ratio[c]}, {6'h0, div1});
            chk("secondary divider", {6'h0, ratio[c]}, {6'h0, div2});
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h03, {(c == 3) ? 2'b00 : c[1:0], c[1:0], 4'h0});
            wr(8'h04, {(c == 3) ? 2'b00 : c[1:0], 1'b0, c[0], 4'h0});
            wr(8'h06, {1'b0, (c == 3) ? 2'b00 : c[1:0], 5'h00});
            chk("playback format", {8'h0, c[1:0]}, {8'h0, pb_fmt});
            chk("record format", {9'h0, c[0]}, {9'h0, rec_fmt});
            chk("playback speed", {8'h0, (c == 3) ? 2'b00 : c[1:0]}, {8'h0, pb_speed});
            chk("record speed", {8'h0, (c == 3) ? 2'b00 : c[1:0]}, {8'h0, rec_speed});
            chk("aux source", {8'h0, (c == 3) ? 2'b00 : c[1:0]}, {8'h0, aux});
        end
        wr(8'h03, 8'h42);
        chk("emphasis double", 10'h000, {9'h0, emph});
        wr(8'h03, 8'h02);
        chk("emphasis single", 10'h001, {9'h0, emph});
        wr(8'h07, 8'h27);
        chk("gain below range", 10'h000, {9'h0, gain_ok});
        chk("config fault set", 10'h001, {9'h0, fault});
        wr(8'h07, 8'h18);
        chk("gain top of range", 10'h001, {9'h0, gain_ok});
        chk("config fault clear", 10'h000, {9'h0, fault});
        wr(8'h03, 8'h04);
        chk("mute pin", 10'h000, {9'h0, mute_n});
        chk("immediate mute level", 10'h3fc, level);
        gradual = 1'b1;
        wr(8'h03, 8'h00);
        chk("mute pin released", 10'h001, {9'h0, mute_n});
        ticks(8);
        chk("soft ramp level", 10'h3f4, level);
        chk("soft ramp right", 10'h3f4, level_r);
        gradual = 1'b0;
        crossing = 1'b1;
        wr(8'h03, 8'h04);
        ticks(500);
        chk("zero cross wait", 10'h3f4, level);
        ticks(530);
        chk("zero cross timeout", 10'h3fc, level);
        chk("reads pending", 10'h000, exp_q.size());
        test_done();
    end
endmodule
